// ===== verilog/fault_irq_params.svh
// Offsets, field positions, reset values and timing counts of the fault/irq control block
`ifndef FAULT_IRQ_PARAMS_SVH
`define FAULT_IRQ_PARAMS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_FLAGS_A 8'h00
`define OFS_FLAGS_B 8'h01
`define OFS_ROUTE_A 8'h02
`define OFS_ROUTE_B 8'h03
`define OFS_ROUTE_C 8'h04
`define OFS_ROUTE_D 8'h05
`define OFS_SLEEP 8'h06
`define OFS_SRST 8'h07
`define OFS_DSP_MODE 8'h08
`define OFS_PWR_CTRL 8'h09
`define OFS_STATUS 8'h0a
`define OFS_PIN_BASE 8'h10
`define NUM_PINS 10
// ------------------------------------------------------------
// Fields and codes
// ------------------------------------------------------------
`define SLEEP_BIT 7
`define SRST_BIT 0
`define PWR_ON_BIT 0
`define PLL_BYP_BIT 1
`define PIN_SEL_IRQ1 8'h07
`define DSP_MODE_PLAY 4'h1
`define DSP_MODE_SENSE 4'h2
`define DSP_MODE_PROT 4'h3
`define DSP_MODE_RST 4'h1
`define REG_RST 8'h00
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define INIT_TIME_NS 100000
`define INIT_CYCLES (`INIT_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== verilog/fault_irq_pkg.sv
// Types shared by the fault/irq control block
package fault_irq_pkg;
  typedef enum logic [1:0] {ST_HW_OFF, ST_INIT, ST_SW_SHUT, ST_PLAY} pwr_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ===== verilog/fault_irq_and_mode_control.sv
// Fault flag latching, interrupt routing, reset/shutdown and DSP mode control
// Functional notes
// - Four interrupt lines, each selectable on any of ten pins.
// - A line is the OR of every flag routed to it.
// - Flag bit positions in the two sticky registers.
// - Per-flag routing field; value 001 picks line one.
// - Pin select 0x07 drives line one on that pin.
// - Writing reset bit 1 restores defaults and self-clears; 0 does nothing.
// - Reset pin low: registers lost, bus does not respond.
// - Reset pin low stops playback at once; host should shut down first.
// - On reset pin release, enter software shutdown awaiting power-up.
// - Software shutdown powers down playback analog, keeps registers.
// - Sleep bit 7 defaults 0; when 1 the battery reset monitor is off.
// - Four-bit mode: 0001 playback, 0010 sense output, 0011 protection.
// - Playback-only keeps sense converters off and protection idle.
// - Playback-only still keeps fault, brownout, volume, supply tracking.
// - PLL bypass in playback-only only with a fast enough master clock.
// - Sense mode powers sense converters and returns their samples.
// - Flags stay set until read or reset.
`include "fault_irq_params.svh"
module fault_irq_and_mode_control
  import fault_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Device pins and events
  input wire logic hw_shutdown_n_i,
  input wire logic [7:0] event_i,
  input wire logic mclk_fast_i,
  // General-purpose pins
  output logic [`NUM_PINS-1:0] gpio_o,
  output logic [`NUM_PINS-1:0] gpio_oe_o,
  // Interrupt lines and power controls
  output logic [3:0] irq_line_o,
  output logic init_busy_o,
  output logic analog_power_o,
  output logic fault_protect_o,
  output logic sense_power_o,
  output logic sense_return_o,
  output logic protect_run_o,
  output logic pll_bypass_o,
  output logic vbat_por_off_o
);
  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  // Route codes 1..4 pick a line; zero and anything above leave it unrouted
  function automatic logic route_hit(input logic [3:0] field, input int line);
    route_hit = (field == 4'(line + 1));
  endfunction

  function automatic logic pin_hit(input byte_t cfg, input int line);
    pin_hit = (cfg == 8'(`PIN_SEL_IRQ1 + line));
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pwr_state_e state_q, state_d;
  logic [9:0] init_cnt_q, init_cnt_d;
  logic [7:0] flags_q, flags_d;
  byte_t route_q [4];
  byte_t pin_cfg_q [`NUM_PINS];
  byte_t sleep_q, pwr_ctrl_q;
  logic [3:0] dsp_mode_q;
  logic [3:0] irq_line_w;
  logic [`NUM_PINS-1:0] gpio_w, gpio_oe_w;
  byte_t rdata_w;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  // Bus is dead while the pin is low and during the post-reset blackout
  wire bus_ok = hw_shutdown_n_i && (state_q == ST_SW_SHUT || state_q == ST_PLAY);
  wire wr_ok = wr_i && bus_ok;
  wire rd_ok = rd_i && bus_ok;
  wire srst_wr = wr_ok && addr_i == `OFS_SRST && wdata_i[`SRST_BIT];
  wire clr_all = srst_wr || !hw_shutdown_n_i;
  wire rd_flags_a = rd_ok && addr_i == `OFS_FLAGS_A;
  wire rd_flags_b = rd_ok && addr_i == `OFS_FLAGS_B;
  wire pin_sel = addr_i >= `OFS_PIN_BASE && addr_i < 8'(`OFS_PIN_BASE + `NUM_PINS);
  wire [3:0] pin_idx = 4'(addr_i - `OFS_PIN_BASE);

  // Internal flag order: oc, uv, ot, bo, cl, sc, ce1, ce2
  wire [7:0] flags_a_w = {flags_q[0], flags_q[1], 1'b0, flags_q[2], flags_q[3],
                          flags_q[4], flags_q[5], 1'b0};
  wire [7:0] flags_b_w = {4'h0, flags_q[6], flags_q[7], 2'b00};
  wire [7:0] flag_rd_clr = {{2{rd_flags_b}}, {6{rd_flags_a}}};

  // Route fields per flag, same order as the flags
  wire [3:0] route_f [8];
  assign route_f[0] = {1'b0, route_q[0][6:4]};
  assign route_f[1] = {1'b0, route_q[0][2:0]};
  assign route_f[2] = {1'b0, route_q[1][2:0]};
  assign route_f[3] = {1'b0, route_q[2][6:4]};
  assign route_f[4] = {1'b0, route_q[3][2:0]};
  assign route_f[5] = {1'b0, route_q[3][6:4]};
  assign route_f[6] = {1'b0, route_q[1][6:4]};
  assign route_f[7] = route_q[2][3:0];

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  // A new event in the cycle of its read keeps the flag set
  assign flags_d = clr_all ? 8'h00 : ((flags_q & ~flag_rd_clr) | event_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ------------------------------------------------------------
  // Interrupt lines and pins
  // ------------------------------------------------------------
  genvar gl, gp;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_line
      logic [7:0] hit;
      for (gp = 0; gp < 8; gp++) begin : g_flag
        assign hit[gp] = flags_q[gp] && route_hit(route_f[gp], gl);
      end
      assign irq_line_w[gl] = |hit;
    end
    for (gp = 0; gp < `NUM_PINS; gp++) begin : g_pin
      logic [3:0] sel;
      for (gl = 0; gl < 4; gl++) begin : g_sel
        assign sel[gl] = pin_hit(pin_cfg_q[gp], gl);
      end
      assign gpio_oe_w[gp] = |sel;
      assign gpio_w[gp] = |(sel & irq_line_w);
    end
  endgenerate

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  // Defaults come back on a soft reset or while the pin holds shutdown
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_q <= '{default: `REG_RST};
      pin_cfg_q <= '{default: `REG_RST};
      sleep_q <= `REG_RST;
      pwr_ctrl_q <= `REG_RST;
      dsp_mode_q <= `DSP_MODE_RST;
    end else if (clr_all) begin
      route_q <= '{default: `REG_RST};
      pin_cfg_q <= '{default: `REG_RST};
      sleep_q <= `REG_RST;
      pwr_ctrl_q <= `REG_RST;
      dsp_mode_q <= `DSP_MODE_RST;
    end else if (wr_ok) begin
      if (addr_i >= `OFS_ROUTE_A && addr_i <= `OFS_ROUTE_D) begin
        route_q[2'(addr_i - `OFS_ROUTE_A)] <= wdata_i;
      end
      if (pin_sel) begin
        pin_cfg_q[pin_idx] <= wdata_i;
      end
      if (addr_i == `OFS_SLEEP) begin
        sleep_q <= wdata_i;
      end
      if (addr_i == `OFS_PWR_CTRL) begin
        pwr_ctrl_q <= wdata_i;
      end
      if (addr_i == `OFS_DSP_MODE) begin
        dsp_mode_q <= wdata_i[3:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    init_cnt_d = 10'h000;
    case (state_q)
      ST_HW_OFF: begin
        state_d = ST_SW_SHUT;
      end
      ST_INIT: begin
        init_cnt_d = init_cnt_q + 10'h001;
        if (init_cnt_q == 10'(`INIT_CYCLES - 1)) begin
          state_d = ST_SW_SHUT;
        end
      end
      ST_SW_SHUT: begin
        if (pwr_ctrl_q[`PWR_ON_BIT]) begin
          state_d = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (!pwr_ctrl_q[`PWR_ON_BIT]) begin
          state_d = ST_SW_SHUT;
        end
      end
      default: begin
        state_d = ST_HW_OFF;
      end
    endcase
    // Pin low overrides everything, with no ramp-down
    if (!hw_shutdown_n_i) begin
      state_d = ST_HW_OFF;
      init_cnt_d = 10'h000;
    end else if (srst_wr) begin
      state_d = ST_INIT;
      init_cnt_d = 10'h000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_HW_OFF;
      init_cnt_q <= 10'h000;
    end else begin
      state_q <= state_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  // ------------------------------------------------------------
  // Power and mode outputs
  // ------------------------------------------------------------
  wire play_d = state_d == ST_PLAY;
  wire mode_play = dsp_mode_q == `DSP_MODE_PLAY;
  wire mode_sense = dsp_mode_q == `DSP_MODE_SENSE;
  wire mode_prot = dsp_mode_q == `DSP_MODE_PROT;
  // Reserved mode code leaves processing idle but the analog path may run
  wire sense_d = play_d && (mode_sense || mode_prot);
  wire prot_d = play_d && mode_prot;
  wire fault_d = play_d && (mode_play || mode_sense || mode_prot);
  wire byp_d = play_d && mode_play && pwr_ctrl_q[`PLL_BYP_BIT] && mclk_fast_i;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    rdata_w = 8'h00;
    if (pin_sel) begin
      rdata_w = pin_cfg_q[pin_idx];
    end
    case (addr_i)
      `OFS_FLAGS_A: rdata_w = flags_a_w;
      `OFS_FLAGS_B: rdata_w = flags_b_w;
      `OFS_ROUTE_A: rdata_w = route_q[0];
      `OFS_ROUTE_B: rdata_w = route_q[1];
      `OFS_ROUTE_C: rdata_w = route_q[2];
      `OFS_ROUTE_D: rdata_w = route_q[3];
      `OFS_SLEEP: rdata_w = sleep_q;
      `OFS_DSP_MODE: rdata_w = {4'h0, dsp_mode_q};
      `OFS_PWR_CTRL: rdata_w = pwr_ctrl_q;
      `OFS_STATUS: rdata_w = {6'h00, state_q};
      default: begin
      end
    endcase
  end

  // ------------------------------------------------------------
  // Output flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      irq_line_o <= 4'h0;
      gpio_o <= '0;
      gpio_oe_o <= '0;
      init_busy_o <= 1'b0;
      analog_power_o <= 1'b0;
      fault_protect_o <= 1'b0;
      sense_power_o <= 1'b0;
      sense_return_o <= 1'b0;
      protect_run_o <= 1'b0;
      pll_bypass_o <= 1'b0;
      vbat_por_off_o <= 1'b0;
    end else begin
      rdata_o <= rd_ok ? rdata_w : 8'h00;
      irq_line_o <= irq_line_w;
      gpio_o <= gpio_w;
      gpio_oe_o <= gpio_oe_w;
      init_busy_o <= state_d == ST_INIT;
      analog_power_o <= play_d;
      fault_protect_o <= fault_d;
      sense_power_o <= sense_d;
      sense_return_o <= sense_d;
      protect_run_o <= prot_d;
      pll_bypass_o <= byp_d;
      vbat_por_off_o <= sleep_q[`SLEEP_BIT];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_FLAG_STICKY: assert property (flags_q[0] && !rd_flags_a && !clr_all |=> flags_q[0])
    else $error("overcurrent flag dropped without a read");
  AST_EVENT_SETS: assert property (event_i[2] && !clr_all |=> flags_a_w[4])
    else $error("overtemp event not recorded at bit 4");
  AST_ROUTE_ONE: assert property (route_q[2][6:4] == 3'b001 && flags_q[3] |=> irq_line_o[0])
    else $error("brownout routed to line one did not raise it");
  AST_ZERO_ROUTE: assert property (route_q[0] == 8'h00 && route_q[1] == 8'h00 &&
    route_q[2] == 8'h00 && route_q[3] == 8'h00 |=> irq_line_o == 4'h0)
    else $error("unrouted flags raised a line");
  AST_PIN_IRQ1: assert property (pin_cfg_q[4] == `PIN_SEL_IRQ1 |=>
    gpio_oe_o[4] && gpio_o[4] == irq_line_o[0])
    else $error("pin four not following line one");
  AST_SRST_DEFAULTS: assert property (srst_wr |=> route_q[0] == 8'h00 &&
    dsp_mode_q == `DSP_MODE_RST && sleep_q == 8'h00)
    else $error("soft reset did not restore defaults");
  AST_BLACKOUT: assert property (srst_wr && hw_shutdown_n_i |=> init_busy_o[*8])
    else $error("blackout not held after soft reset");
  // Blackout is too long for a delay range, so its length is counted here
  logic [10:0] busy_cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_q <= 11'h000;
    end else begin
      busy_cnt_q <= init_busy_o ? busy_cnt_q + 11'h001 : 11'h000;
    end
  end

  // A pin drop may cut the blackout short, so only a natural end is timed
  AST_BLACKOUT_END: assert property ($fell(init_busy_o) && $past(hw_shutdown_n_i) |->
    busy_cnt_q == 11'(`INIT_CYCLES))
    else $error("blackout length wrong");
  AST_BLACKOUT_MAX: assert property (busy_cnt_q <= 11'(`INIT_CYCLES))
    else $error("blackout held too long");
  AST_HW_NO_BUS: assert property (!hw_shutdown_n_i && rd_i |=> rdata_o == 8'h00)
    else $error("bus answered in hardware shutdown");
  AST_HW_STOP: assert property (!hw_shutdown_n_i |=> !analog_power_o)
    else $error("playback kept running with pin low");
  AST_RELEASE: assert property (state_q == ST_HW_OFF && hw_shutdown_n_i |=>
    state_q == ST_SW_SHUT)
    else $error("release did not enter software shutdown");
  AST_MODE1_SENSE: assert property (mode_play |=> !sense_power_o && !protect_run_o)
    else $error("sense or protection active in playback-only");
  AST_SLEEP: assert property (vbat_por_off_o == $past(sleep_q[`SLEEP_BIT]))
    else $error("battery monitor control wrong");

  COV_SHARED_LINE: cover property (flags_q[0] && flags_q[1] && irq_line_o[0]);
  COV_SRST_DONE: cover property (init_busy_o ##1 !init_busy_o);
  COV_SENSE_PLAY: cover property (sense_return_o && analog_power_o);
  COV_HW_DURING_PLAY: cover property (analog_power_o && !hw_shutdown_n_i);
endmodule

// ===== verification/host_bus_model.sv
// Host processor model driving the register port of the fault/irq block
`include "fault_irq_params.svh"
module host_bus_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // ----
  // Bus cycles
  // ----
  // Idle lines show the inverse so that a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Shared lines are told apart only by reading the sticky flags
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
  // Soft reset after every hardware reset, then a quiet spell
  task automatic srst();
    wr(`OFS_SRST, 8'h01);
    repeat (`INIT_CYCLES + 4) @(posedge clk_i);
  endtask
endmodule

// ===== verification/fault_irq_and_mode_control_tb.sv
// Self-checking bench of the fault/irq and mode control block
`include "fault_irq_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module fault_irq_and_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wr_i, rd_i, hw_n, mclk_fast_i;
  logic [7:0] addr_i, wdata_i, rdata_o, event_i, d;
  logic [9:0] gpio_o, gpio_oe_o;
  logic [3:0] irq_line_o;
  logic init_busy_o, analog_power_o, fault_protect_o, sense_power_o;
  logic sense_return_o, protect_run_o, pll_bypass_o, vbat_por_off_o;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] raddr [8] = '{8'h02, 8'h02, 8'h03, 8'h04, 8'h05, 8'h05, 8'h03, 8'h04};
  int rsh [8] = '{4, 0, 0, 4, 0, 4, 4, 0};
  int fbit [8] = '{7, 6, 4, 3, 2, 1, 3, 2};
  logic [5:0] mexp [4] = '{6'b100000, 6'b110001, 6'b111100, 6'b111110};
  fault_irq_and_mode_control dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .hw_shutdown_n_i(hw_n), .event_i(event_i), .mclk_fast_i(mclk_fast_i),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .irq_line_o(irq_line_o),
    .init_busy_o(init_busy_o), .analog_power_o(analog_power_o),
    .fault_protect_o(fault_protect_o), .sense_power_o(sense_power_o),
    .sense_return_o(sense_return_o), .protect_run_o(protect_run_o),
    .pll_bypass_o(pll_bypass_o), .vbat_por_off_o(vbat_por_off_o));
  host_bus_model host (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
    .rd_o(rd_i), .rdata_i(rdata_o));
  // ----
  // Clock, watchdog and closing
  // ----
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // About 3000 cycles are needed; allow a wide margin
  initial begin
    #(20000 * 100);
    n_mismatch++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One-cycle event, then wait for flag and line to settle
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_i);
    event_i <= e;
    @(posedge clk_i);
    event_i <= 8'h00;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    rst_i = 1'b1;
    hw_n = 1'b1;
    event_i = 8'h00;
    mclk_fast_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    host.rd(`OFS_STATUS, d);
    `CHK(d[1:0], 2'h2)
    fork
      host.srst();
      begin
        settle();
        `CHK(init_busy_o, 1'b1)
      end
    join
    `CHK(init_busy_o, 1'b0)
    host.rd(`OFS_SLEEP, d);
    `CHK(d, 8'h00)
    host.rd(`OFS_SRST, d);
    `CHK(d, 8'h00)
    host.rd(`OFS_DSP_MODE, d);
    `CHK(d, 8'h01)
    host.rd(8'h30, d);
    `CHK(d, 8'h00)
    for (int k = 0; k < 4; k++) begin
      host.wr(8'(`OFS_PIN_BASE + k), 8'(`PIN_SEL_IRQ1 + k));
    end
    for (int k = 0; k < 8; k++) begin
      host.wr(raddr[k], 8'((k % 4 + 1) << rsh[k]));
      pulse(8'(1 << k));
      `CHK(irq_line_o, 4'(1 << (k % 4)))
      `CHK({gpio_oe_o[3:0], gpio_o[3:0]}, {4'hf, 4'(1 << (k % 4))})
      host.rd(k < 6 ? `OFS_FLAGS_A : `OFS_FLAGS_B, d);
      `CHK(d, 8'(1 << fbit[k]))
      host.rd(k < 6 ? `OFS_FLAGS_A : `OFS_FLAGS_B, d);
      `CHK(d, 8'h00)
      `CHK(irq_line_o, 4'h0)
      host.wr(raddr[k], 8'h00);
    end
    // Brownout and under-voltage share line one on pin four
    host.wr(`OFS_ROUTE_C, 8'h10);
    host.wr(`OFS_ROUTE_A, 8'h01);
    host.wr(8'(`OFS_PIN_BASE + 4), `PIN_SEL_IRQ1);
    pulse(8'h0a);
    `CHK(irq_line_o, 4'h1)
    `CHK({gpio_oe_o[4], gpio_o[4]}, 2'b11)
    `CHK(gpio_oe_o[9:5], 5'h00)
    host.rd(`OFS_FLAGS_A, d);
    `CHK(d, 8'h48)
    host.wr(`OFS_ROUTE_A, 8'h00);
    pulse(8'h01);
    `CHK(irq_line_o, 4'h0)
    host.rd(`OFS_FLAGS_A, d);
    `CHK(d, 8'h80)
    // Power up and walk the processing modes
    host.wr(`OFS_PWR_CTRL, 8'h03);
    for (int m = 0; m <= 3; m++) begin
      host.wr(`OFS_DSP_MODE, 8'(m));
      settle();
      `CHK({analog_power_o, fault_protect_o, sense_power_o, sense_return_o, protect_run_o,
        pll_bypass_o}, mexp[m])
    end
    host.wr(`OFS_DSP_MODE, 8'h01);
    @(posedge clk_i);
    mclk_fast_i <= 1'b0;
    settle();
    `CHK(pll_bypass_o, 1'b0)
    host.rd(`OFS_STATUS, d);
    `CHK(d[1:0], 2'h3)
    host.wr(`OFS_PWR_CTRL, 8'h00);
    settle();
    `CHK(analog_power_o, 1'b0)
    host.rd(`OFS_DSP_MODE, d);
    `CHK(d, 8'h01)
    host.wr(`OFS_SLEEP, 8'h80);
    settle();
    `CHK(vbat_por_off_o, 1'b1)
    host.wr(`OFS_SRST, 8'h00);
    host.rd(`OFS_SLEEP, d);
    `CHK(d, 8'h80)
    // Reset pin pulled low in mid-playback
    host.wr(`OFS_PWR_CTRL, 8'h01);
    settle();
    `CHK(analog_power_o, 1'b1)
    @(posedge clk_i);
    hw_n <= 1'b0;
    settle();
    `CHK(analog_power_o, 1'b0)
    host.rd(`OFS_DSP_MODE, d);
    `CHK(d, 8'h00)
    @(posedge clk_i);
    hw_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    host.rd(`OFS_STATUS, d);
    `CHK(d[1:0], 2'h2)
    host.rd(`OFS_SLEEP, d);
    `CHK(d, 8'h00)
    host.srst();
    host.wr(`OFS_SLEEP, 8'h80);
    host.wr(`OFS_DSP_MODE, 8'h03);
    host.srst();
    host.rd(`OFS_SLEEP, d);
    `CHK(d, 8'h00)
    host.rd(`OFS_DSP_MODE, d);
    `CHK(d, 8'h01)
    complete_run();
  end
endmodule
